//--- core/pmd_core.sv
`timescale 1ns/1ps
`default_nettype none
module pmd_core
	import pmd_pkg::*;
#(
	parameter int unsigned ON_CYC_P = ON_CYC,
	parameter int unsigned MOD_DIV_HALF_P = MOD_DIV_HALF
)(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Modulator bitstream
	input wire logic modulator_bit,
	// AXI4-Lite slave
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Display drive
	output logic [N_DIG-1:0] digit_cathode_en,
	output var pmd_seg_t segment_drive
);
	pmd_ctrl_t ctrl_r;
	logic half;
	logic var_q_r;
	logic var_chg;
	logic [1:0] mod_sync_r;
	logic [31:0] phase_r;
	logic fclk_en_r;
	logic [12:0] mdiv_r;
	logic mdiv_last;
	logic mod_en_r;
	logic [CIC_W-1:0] integ_r [4];
	logic [CIC_W-1:0] dly_r [4];
	logic [CIC_W-1:0] cy [5];
	logic [9:0] dcnt_r;
	logic prime_r;
	logic dec_last;
	logic res_take;
	logic [CIC_W-1:0] y_n;
	logic signed [CIC_W:0] y_c;
	logic signed [CIC_W+16:0] prod;
	logic signed [CNT_W-1:0] result_r;
	logic res_v_r;
	logic [2:0] res_cnt_r;
	logic par_r;
	logic upd_r;
	logic signed [CNT_W-1:0] peak_r;
	logic peak_v_r;
	logic signed [CNT_W-1:0] sel_v;
	logic signed [CNT_W-1:0] lim;
	logic signed [CNT_W-1:0] shown_r;
	logic ovr_r;
	logic und_r;
	logic pe_l_r;
	logic over;
	logic under;
	logic neg;
	logic [CNT_W-1:0] mag;
	logic [19:0] bcd;
	logic [2:0] dpi;
	logic [2:0] keep;
	logic [2:0] top;
	pmd_seg_t pat_r [N_DIG];
	pmd_scan_t st_r;
	logic [16:0] tcnt_r;
	logic [2:0] slot_r;
	logic tlast;
	logic aw_got_r;
	logic w_got_r;
	logic [ADDR_W-1:0] awaddr_r;
	logic [31:0] wdata_r;
	logic [3:0] wstrb_r;
	logic wr_do;

	assign half = ctrl_r.variant_half;
	assign var_chg = var_q_r != half;

	// The pin is asynchronous to ref_clk, so it is resynchronised first.
	always_ff @(posedge ref_clk)
		if (rst)
			mod_sync_r <= 2'h0;
		else
			mod_sync_r <= {mod_sync_r[0], modulator_bit};

	always_ff @(posedge ref_clk)
		if (rst)
			var_q_r <= 1'b0;
		else
			var_q_r <= half;

	// Fractional divider; enable jitter is one ref_clk period at most.
	always_ff @(posedge ref_clk)
		if (rst)
		begin
			phase_r <= 32'h0;
			fclk_en_r <= 1'b0;
		end
		else
			{fclk_en_r, phase_r} <= {1'b0, phase_r} + {1'b0, FCLK_INC}; // R6 R8

	assign mdiv_last = mdiv_r ==
		13'(half ? MOD_DIV_HALF_P - 1 : MOD_DIV_FULL - 1);

	// One modulator bit per tick, rate chosen so that ratio ticks give 5 Hz.
	always_ff @(posedge ref_clk)
		if (rst || var_chg)
		begin
			mdiv_r <= 13'h0;
			mod_en_r <= 1'b0;
		end
		else
		begin
			mod_en_r <= fclk_en_r && mdiv_last; // R1 R4
			if (fclk_en_r)
				mdiv_r <= mdiv_last ? 13'h0 : mdiv_r + 13'h1;
		end

	assign dec_last = dcnt_r == 10'(half ? RATIO_HALF - 1 : RATIO_FULL - 1);
	assign res_take = mod_en_r && dec_last;
	assign cy[0] = integ_r[3];

	// Modular integrator arithmetic is exact as long as the combs differ.
	genvar k;
	for (k = 0; k < 4; k++)
	begin : g_cic
		logic [CIC_W-1:0] stage_in;
		if (k == 0)
			assign stage_in = {{(CIC_W-1){1'b0}}, mod_sync_r[1]}; // R1
		else
			assign stage_in = integ_r[k-1];
		assign cy[k+1] = cy[k] - dly_r[k]; // R2
		always_ff @(posedge ref_clk)
			if (rst || var_chg)
			begin
				integ_r[k] <= '0;
				dly_r[k] <= '0;
			end
			else
			begin
				if (mod_en_r)
					integ_r[k] <= integ_r[k] + stage_in; // R2
				if (res_take)
					dly_r[k] <= cy[k];
			end
	end

	// The first tick after a restart is not counted, so every take sees the
	// integrators one tick later and the fourth result holds a full window.
	always_ff @(posedge ref_clk)
		if (rst || var_chg)
		begin
			dcnt_r <= 10'h0;
			prime_r <= 1'b0;
		end
		else if (mod_en_r)
		begin
			prime_r <= 1'b1; // R5
			if (prime_r)
				dcnt_r <= dec_last ? 10'h0 : dcnt_r + 10'h1; // R3
		end

	// Scaled so that a full-density stream reads 1.25 times full scale.
	assign y_n = half ? (cy[4] << HALF_SHIFT) : cy[4];
	assign y_c = $signed({1'b0, y_n}) - $signed(CIC_MID);
	assign prod = y_c * (half ? SCALE_HALF : SCALE_FULL); // R7

	always_ff @(posedge ref_clk)
		if (rst || var_chg)
		begin
			result_r <= '0;
			res_v_r <= 1'b0;
			res_cnt_r <= 3'h0;
			par_r <= 1'b0;
			upd_r <= 1'b0;
		end
		else
		begin
			res_v_r <= res_take;
			upd_r <= res_v_r && par_r; // R10
			if (res_take)
			begin
				result_r <= prod[CNT_W+MID_SHIFT-1:MID_SHIFT]; // R7
				par_r <= ~par_r;
				if (res_cnt_r != SETTLE_RES)
					res_cnt_r <= res_cnt_r + 3'h1; // R5
			end
		end

	always_ff @(posedge ref_clk)
		if (rst || !ctrl_r.peak)
		begin
			peak_r <= '0;
			peak_v_r <= 1'b0;
		end
		else if (res_v_r && (!peak_v_r || result_r > peak_r))
		begin
			peak_r <= result_r; // R21
			peak_v_r <= 1'b1;
		end

	assign sel_v = (ctrl_r.peak && peak_v_r) ? peak_r : result_r; // R18
	assign lim = half ? LIM_HALF : LIM_FULL;
	assign over = sel_v > lim;
	assign under = sel_v < -lim;
	assign neg = sel_v[CNT_W-1];
	assign mag = neg ? -sel_v : sel_v;
	assign bcd = pmd_bcd(mag[16:0]);
	assign dpi = half ? {1'b0, ctrl_r.point_position_msb,
		ctrl_r.point_position_lsb} : {1'b0, ctrl_r.point_position_msb,
		ctrl_r.point_position_lsb} + 3'h1; // R15 R16
	assign keep = ctrl_r.point_enable ? dpi : 3'h0;
	assign top = half ? 3'h3 : 3'h4; // R9

	// Hold simply stops the latch, so the frozen value is what is lit.
	always_ff @(posedge ref_clk)
		if (rst)
		begin
			shown_r <= '0;
			ovr_r <= 1'b0;
			und_r <= 1'b0;
			pe_l_r <= 1'b0;
		end
		else if (upd_r && !ctrl_r.hold) // R18 R23 R25
		begin
			shown_r <= sel_v;
			ovr_r <= over;
			und_r <= under;
			pe_l_r <= ctrl_r.point_enable;
		end

	// Patterns are built once per update so a scan never mixes values.
	for (k = 0; k < N_DIG; k++)
	begin : g_dig
		logic [2:0] li;
		logic [19:0] sh;
		logic lit;
		logic is_top;
		pmd_seg_t pat;
		assign li = 3'(k) - {2'h0, half}; // R24
		assign sh = bcd >> {li, 2'h0};
		assign lit = (|sh) || li <= keep; // R17
		assign is_top = li == top;
		always_comb
		begin
			pat = SEG_OFF;
			if (half && k == 0)
				pat = SEG_OFF;
			else if (over)
				pat = is_top ? SEG_ONE : SEG_OFF; // R22
			else if (under)
				pat = is_top ? (SEG_ONE | SEG_MINUS) : SEG_OFF; // R22
			else
			begin
				if (lit)
					pat = pmd_seg_t'({1'b0, pmd_seg7(sh[3:0])});
				if (is_top && neg)
					pat = pat | SEG_MINUS;
				if (ctrl_r.point_enable && li == dpi)
					pat = pat | SEG_POINT; // R15 R16
			end
		end
		always_ff @(posedge ref_clk)
			if (rst)
				pat_r[k] <= SEG_OFF;
			else if (upd_r && !ctrl_r.hold)
				pat_r[k] <= pat; // R25
	end

	assign tlast = (st_r == ST_BLANK) ? tcnt_r == 17'(BLANK_CYC - 1) :
		tcnt_r == 17'(ON_CYC_P - BLANK_CYC - 1);

	// Each slot is a blank gap followed by the lit part, ON_CYC_P in all.
	always_ff @(posedge ref_clk)
		if (rst)
		begin
			st_r <= ST_BLANK;
			tcnt_r <= 17'h0;
			slot_r <= 3'h0;
		end
		else
		begin
			tcnt_r <= tlast ? 17'h0 : tcnt_r + 17'h1; // R12 R13
			case (st_r)
				ST_BLANK:
					if (tlast)
						st_r <= ST_ON; // R20
				ST_ON:
					if (tlast)
					begin
						st_r <= ST_BLANK; // R19
						slot_r <= (slot_r == 3'(N_DIG - 1)) ? 3'h0 :
							slot_r + 3'h1; // R24
					end
				default:
					st_r <= ST_BLANK;
			endcase
		end

	always_ff @(posedge ref_clk)
		if (rst)
		begin
			digit_cathode_en <= '0;
			segment_drive <= SEG_OFF;
		end
		else if (st_r == ST_ON)
		begin
			digit_cathode_en <= 5'(5'h01 << slot_r); // R11
			segment_drive <= pat_r[slot_r]; // R14
		end
		else
		begin
			digit_cathode_en <= '0; // R19
			segment_drive <= SEG_OFF;
		end

	assign wr_do = aw_got_r && w_got_r && !s_axi_bvalid;

	always_ff @(posedge ref_clk)
		if (rst)
		begin
			aw_got_r <= 1'b0;
			s_axi_awready <= 1'b1;
			awaddr_r <= '0;
		end
		else if (s_axi_awvalid && s_axi_awready)
		begin
			aw_got_r <= 1'b1;
			s_axi_awready <= 1'b0;
			awaddr_r <= s_axi_awaddr;
		end
		else if (wr_do)
			aw_got_r <= 1'b0;
		else if (s_axi_bvalid && s_axi_bready)
			s_axi_awready <= 1'b1;

	always_ff @(posedge ref_clk)
		if (rst)
		begin
			w_got_r <= 1'b0;
			s_axi_wready <= 1'b1;
			wdata_r <= 32'h0;
			wstrb_r <= 4'h0;
		end
		else if (s_axi_wvalid && s_axi_wready)
		begin
			w_got_r <= 1'b1;
			s_axi_wready <= 1'b0;
			wdata_r <= s_axi_wdata;
			wstrb_r <= s_axi_wstrb;
		end
		else if (wr_do)
			w_got_r <= 1'b0;
		else if (s_axi_bvalid && s_axi_bready)
			s_axi_wready <= 1'b1;

	always_ff @(posedge ref_clk)
		if (rst)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end
		else if (wr_do)
		begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= (awaddr_r == ADDR_CTRL) ? RESP_OKAY : RESP_SLVERR;
		end
		else if (s_axi_bready)
			s_axi_bvalid <= 1'b0;

	always_ff @(posedge ref_clk)
		if (rst)
			ctrl_r <= CTRL_RST;
		else if (wr_do && awaddr_r == ADDR_CTRL && wstrb_r[0])
			ctrl_r <= pmd_ctrl_t'(wdata_r[5:0]);

	always_ff @(posedge ref_clk)
		if (rst)
		begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= RESP_OKAY;
			case (s_axi_araddr)
				ADDR_CTRL: s_axi_rdata <= {26'h0, ctrl_r};
				ADDR_RESULT: s_axi_rdata <= 32'(result_r);
				ADDR_SHOWN: s_axi_rdata <= 32'(shown_r);
				ADDR_STATUS: s_axi_rdata <= {28'h0, peak_v_r, und_r, ovr_r,
					res_cnt_r == SETTLE_RES}; // R5
				default:
				begin
					s_axi_rdata <= 32'h0;
					s_axi_rresp <= RESP_SLVERR;
				end
			endcase
		end
		else if (s_axi_rvalid && s_axi_rready)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end

	// Helper state for the checks below.
	logic lvl_q_r;
	logic seen_r;
	logic [16:0] run_r;
	logic [N_DIG-1:0] prev_on_r;
	logic [10:0] msamp_r;

	always_ff @(posedge ref_clk)
		if (rst)
		begin
			lvl_q_r <= 1'b0;
			seen_r <= 1'b0;
			run_r <= 17'h0;
			prev_on_r <= 5'h10;
			msamp_r <= 11'h0;
		end
		else
		begin
			lvl_q_r <= |digit_cathode_en;
			run_r <= (lvl_q_r != |digit_cathode_en) ? 17'h1 : run_r + 17'h1;
			if (lvl_q_r != |digit_cathode_en)
				seen_r <= 1'b1;
			if (|digit_cathode_en)
				prev_on_r <= digit_cathode_en;
			if (res_take)
				msamp_r <= 11'h0;
			else if (mod_en_r)
				msamp_r <= msamp_r + 11'h1;
		end

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst || var_chg);

	a_one_digit: assert property ($onehot0(digit_cathode_en)) // R11
		else $error("more than one digit enabled");
	a_blank_dark: assert property (digit_cathode_en == '0 |-> // R19
		segment_drive == SEG_OFF)
		else $error("segments lit while no digit enabled");
	a_blank_len: assert property (seen_r && $rose(|digit_cathode_en) |-> // R20
		run_r == 17'(BLANK_CYC))
		else $error("blanking gap has wrong length");
	a_on_len: assert property (seen_r && $fell(|digit_cathode_en) |-> // R13
		run_r == 17'(ON_CYC_P - BLANK_CYC))
		else $error("digit on time has wrong length");
	a_scan_order: assert property (seen_r && $rose(|digit_cathode_en) |-> // R24
		digit_cathode_en == {prev_on_r[3:0], prev_on_r[4]})
		else $error("digit order broken");
	a_ratio_count: assert property (res_cnt_r != 3'h0 && res_take |-> // R3
		msamp_r == 11'(half ? RATIO_HALF - 1 : RATIO_FULL - 1))
		else $error("decimation ratio wrong");
	a_peak_mono: assert property (ctrl_r.peak && peak_v_r && // R21
		$past(peak_v_r) |-> peak_r >= $past(peak_r))
		else $error("peak value decreased");
	a_hold_freeze: assert property (ctrl_r.hold && $past(ctrl_r.hold) |-> // R23
		$stable(shown_r) && $stable(pe_l_r))
		else $error("shown value changed during hold");
	a_live_show: assert property (upd_r && !ctrl_r.hold && // R18
		!ctrl_r.peak |=> shown_r == $past(result_r))
		else $error("latest result not shown");
	a_point_off: assert property (!pe_l_r && !$past(pe_l_r) |-> // R15
		!segment_drive.point)
		else $error("point lit while disabled");

	c_hold_on: cover property ($rose(ctrl_r.hold));
	c_peak_up: cover property (peak_v_r && $past(peak_v_r) &&
		peak_r > $past(peak_r));
	c_overrange: cover property ($rose(ovr_r));
	c_full_scan: cover property ($rose(digit_cathode_en[4]));
endmodule
`default_nettype wire

//--- core/pmd_pkg.sv
// What this block does
// [R1] Filter input is one modulator bit per tick.
// [R2] Sinc4 filter: four cascaded averaging stages.
// [R3] Oversampling ratio 128 or 1024 per variant.
// [R4] Results arrive at 5 Hz.
// [R5] Four results needed before output counts settled.
// [R6] Filter clock is 4.9152 MHz.
// [R7] Datapath carries 25 percent overrange unwrapped.
// [R8] Timing from internal clock, no external clock.
// [R9] Drive 4.5 or 3.5 digits, common cathode.
// [R10] New display value every 400 ms.
// [R11] Exactly one digit cathode enabled at once. The code enables none during the blanking gaps.
// [R12] Full five-slot scan takes about 1.9531 ms.
// [R13] Each digit slot lasts one fifth of scan.
// [R14] Segment outputs shared across all digits.
// [R15] 4.5 digits: point before last 1-4 digits.
// [R16] 3.5 digits: point after last, or before 1-3.
// [R17] Blank leading zeros, keep digits from point rightward.
// [R18] Priority: hold, then peak, then latest result.
// [R19] All segments off between digit enables.
// [R20] Blanking gap lasts 4 us.
// [R21] Peak starts at current, rises only; clears off.
// [R22] Overrange shows 1, underrange shows -1.
// [R23] Hold freezes the shown value.
// [R24] Digits step cyclically through all five slots.
// [R25] Latch value and point settings per update.
package pmd_pkg;
	localparam int unsigned CLK_HZ = 250000000;
	localparam int unsigned CLK_NS = 4;
	localparam longint unsigned FCLK_HZ = 4915200;
	localparam int unsigned ODR_HZ = 5;
	localparam int unsigned RATIO_FULL = 1024;
	localparam int unsigned RATIO_HALF = 128;
	localparam int unsigned MOD_DIV_FULL =
		32'(FCLK_HZ / (ODR_HZ * RATIO_FULL));
	localparam int unsigned MOD_DIV_HALF =
		32'(FCLK_HZ / (ODR_HZ * RATIO_HALF));
	localparam logic [31:0] FCLK_INC = 32'((FCLK_HZ << 32) / CLK_HZ);
	localparam int unsigned T_ON_NS = 390600;
	localparam int unsigned T_BLANK_NS = 4000;
	localparam int unsigned ON_CYC = T_ON_NS / CLK_NS;
	localparam int unsigned BLANK_CYC = (T_BLANK_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned N_DIG = 5;
	localparam int unsigned CIC_W = 41;
	localparam int unsigned CNT_W = 18;
	localparam int unsigned HALF_SHIFT = 12;
	localparam int unsigned MID_SHIFT = 39;
	localparam logic [CIC_W:0] CIC_MID = 42'h080_0000_0000;
	localparam logic [2:0] SETTLE_RES = 3'h4;
	localparam logic signed [15:0] SCALE_FULL = 16'sh61a8;
	localparam logic signed [15:0] SCALE_HALF = 16'sh09c4;
	localparam logic signed [CNT_W-1:0] LIM_FULL = 18'sh04e1f;
	localparam logic signed [CNT_W-1:0] LIM_HALF = 18'sh007cf;
	localparam int unsigned ADDR_W = 4;
	localparam logic [3:0] ADDR_CTRL = 4'h0;
	localparam logic [3:0] ADDR_RESULT = 4'h4;
	localparam logic [3:0] ADDR_SHOWN = 4'h8;
	localparam logic [3:0] ADDR_STATUS = 4'hc;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [5:0] CTRL_RST = 6'h00;

	typedef struct packed {
		logic variant_half;
		logic peak;
		logic hold;
		logic point_position_lsb;
		logic point_position_msb;
		logic point_enable;
	} pmd_ctrl_t;

	typedef struct packed {
		logic point;
		logic g;
		logic f;
		logic e;
		logic d;
		logic c;
		logic b;
		logic a;
	} pmd_seg_t;

	typedef enum logic [1:0] {
		ST_BLANK = 2'h1,
		ST_ON = 2'h2
	} pmd_scan_t;

	localparam pmd_seg_t SEG_OFF = 8'h00;
	localparam pmd_seg_t SEG_ONE = 8'h06;
	localparam pmd_seg_t SEG_MINUS = 8'h40;
	localparam pmd_seg_t SEG_POINT = 8'h80;

	function automatic logic [6:0] pmd_seg7(input logic [3:0] v);
		case (v)
			4'h0: return 7'h3f;
			4'h1: return 7'h06;
			4'h2: return 7'h5b;
			4'h3: return 7'h4f;
			4'h4: return 7'h66;
			4'h5: return 7'h6d;
			4'h6: return 7'h7d;
			4'h7: return 7'h07;
			4'h8: return 7'h7f;
			4'h9: return 7'h6f;
			default: return 7'h00;
		endcase
	endfunction

	function automatic logic [19:0] pmd_bcd(input logic [16:0] b);
		logic [36:0] s;
		s = {20'h00000, b};
		for (int i = 0; i < 17; i++)
		begin
			for (int d = 0; d < 5; d++)
				if (s[17+4*d +: 4] > 4'h4)
					s[17+4*d +: 4] = s[17+4*d +: 4] + 4'h3;
			s = s << 1;
		end
		return s[36:17];
	endfunction
endpackage

//--- tb/pmd_led_model.sv
`timescale 1ns/1ps
`default_nettype none
module pmd_led_model
	import pmd_pkg::*;
(
	// Clock and control
	input wire logic ref_clk,
	input wire logic clear,
	input wire logic half,
	// Display drive seen by the LED digits
	input wire logic [N_DIG-1:0] digit_cathode_en,
	input wire pmd_seg_t segment_drive,
	// What the display showed
	output logic [8*N_DIG-1:0] slot_seg,
	output logic [N_DIG-1:0] lit_mask,
	output logic [15:0] faults,
	output logic [31:0] on_len,
	output logic [31:0] gap_min,
	output logic [31:0] scan_len
);
	logic [N_DIG-1:0] pcat;
	pmd_seg_t pseg;
	int cnt, last, t, t1, idx, nx;

	// The digits are passive; they only record what lights up and when.
	always @(posedge ref_clk)
	begin
		t = t + 1;
		if (clear)
		begin
			{slot_seg, lit_mask, faults, on_len, scan_len} = '0;
			gap_min = 32'hffff_ffff;
			last = -1;
			t1 = -1;
			cnt = 0;
		end
		else if (digit_cathode_en != '0)
		begin
			if (!$onehot(digit_cathode_en))
				faults++;
			for (int i = 0; i < N_DIG; i++)
				if (digit_cathode_en[i])
					idx = i;
			if (half && idx == 0 && segment_drive != SEG_OFF)
				faults++;
			if (pcat == '0)
			begin
				nx = (last == N_DIG - 1) ? 0 : last + 1;
				if (last >= 0 && idx != nx)
					faults++;
				if (last >= 0 && cnt < gap_min)
					gap_min = cnt;
				if (idx == 1 && t1 >= 0)
					scan_len = t - t1;
				if (idx == 1)
					t1 = t;
				last = idx;
				cnt = 1;
			end
			else
			begin
				if (digit_cathode_en != pcat || segment_drive != pseg)
					faults++;
				cnt++;
			end
			slot_seg[idx*8 +: 8] = segment_drive;
			lit_mask = lit_mask | digit_cathode_en;
		end
		else
		begin
			if (segment_drive != SEG_OFF)
				faults++;
			if (pcat != '0)
				on_len = cnt;
			cnt = (pcat != '0) ? 1 : cnt + 1;
		end
		pcat = digit_cathode_en;
		pseg = segment_drive;
	end
endmodule
`default_nettype wire

//--- tb/pmd_core_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin bad_count++; $display("unexpected %s exp %h got %h", n, e, a); end end
module pmd_core_bench
	import pmd_pkg::*;
;
	localparam int unsigned ON_P = 1100;
	typedef struct {
		string n;
		logic [31:0] d;
		logic [31:0] m;
		logic [1:0] r;
	} pmd_exp_t;
	pmd_exp_t rq[$], wq[$], e;
	logic ref_clk = 1'h0;
	logic rst = 1'h1;
	logic modulator_bit = 1'h0;
	logic lvl = 1'h0;
	logic rnd_on = 1'h1;
	logic clear = 1'h0;
	logic half = 1'h0;
	logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h0;
	logic [31:0] s_axi_wdata = 32'h0, rv, d, s_axi_rdata;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [N_DIG-1:0] digit_cathode_en, lit_mask;
	pmd_seg_t segment_drive;
	logic [8*N_DIG-1:0] slot_seg;
	logic [15:0] faults;
	logic [31:0] on_len, gap_min, scan_len;
	int seed = 32'haa3d;
	int bad_count = 0;
	int compares = 0;

	pmd_core #(.ON_CYC_P(ON_P), .MOD_DIV_HALF_P(1)) u_pmd_core (
		.ref_clk(ref_clk), .rst(rst), .modulator_bit(modulator_bit),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .digit_cathode_en(digit_cathode_en),
		.segment_drive(segment_drive)
	);
	pmd_led_model u_pmd_led_model (
		.ref_clk(ref_clk), .clear(clear), .half(half),
		.digit_cathode_en(digit_cathode_en), .segment_drive(segment_drive),
		.slot_seg(slot_seg), .lit_mask(lit_mask), .faults(faults),
		.on_len(on_len), .gap_min(gap_min), .scan_len(scan_len)
	);

	always #2 ref_clk = ~ref_clk;

	always @(posedge ref_clk)
		modulator_bit <= rnd_on ? 1'($random(seed)) : lvl;

	// Responses are judged in arrival order against the notes left by tasks.
	always @(posedge ref_clk)
	begin
		if (s_axi_bvalid && s_axi_bready && wq.size() > 0)
		begin
			e = wq.pop_front();
			`CHK(e.n, e.r, s_axi_bresp)
		end
		if (s_axi_rvalid && s_axi_rready && rq.size() > 0)
		begin
			e = rq.pop_front();
			`CHK(e.n, e.r, s_axi_rresp)
			`CHK(e.n, e.d & e.m, s_axi_rdata & e.m)
		end
	end

	task automatic wr(input logic [3:0] a, input logic [31:0] v,
		input logic [3:0] s, input logic [1:0] r);
		wq.push_back('{"bresp", 32'h0, 32'h0, r});
		@(posedge ref_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		for (int k = 0; k < 100; k++)
		begin
			@(posedge ref_clk);
			if (s_axi_awvalid && s_axi_awready)
				s_axi_awvalid <= 1'h0;
			if (s_axi_wvalid && s_axi_wready)
				s_axi_wvalid <= 1'h0;
			if (s_axi_bvalid)
				break;
		end
		s_axi_bready <= 1'h0;
	endtask

	task automatic rd(input logic [3:0] a, input logic [31:0] v,
		input logic [31:0] m, input logic [1:0] r, input string n);
		rq.push_back('{n, v, m, r});
		@(posedge ref_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		for (int k = 0; k < 100; k++)
		begin
			@(posedge ref_clk);
			if (s_axi_arvalid && s_axi_arready)
				s_axi_arvalid <= 1'h0;
			rv = s_axi_rdata;
			if (s_axi_rvalid)
				break;
		end
		s_axi_rready <= 1'h0;
	endtask

	task automatic scan(input string t, input int w);
		@(posedge ref_clk) clear <= 1'h1;
		@(posedge ref_clk) clear <= 1'h0;
		repeat (w) @(posedge ref_clk);
		`CHK("leading digit", SEG_ONE, slot_seg[39:32])
		`CHK("other digits", 24'h0, slot_seg[31:8])
		`CHK("dark slot", SEG_OFF, slot_seg[7:0])
		`CHK("slots used", 5'h1f, lit_mask)
		`CHK("scan faults", 16'h0, faults)
		`CHK("on time", ON_P - BLANK_CYC, on_len)
		`CHK("blank gap", BLANK_CYC, gap_min)
		$display("test %s done", t);
	endtask

	task automatic test_done;
		`CHK("pending", 0, wq.size() + rq.size())
		$display("compares %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	initial
	begin
		repeat (3) @(posedge ref_clk);
		rst <= 1'h0;
	end

	// Longest path: settling plus a frozen-display wait, with margin.
	initial
	begin
		#360000;
		bad_count++;
		test_done;
	end

	initial
	begin
		repeat (2) @(posedge ref_clk);
		#1;
		`CHK("reset cathodes", 5'h0, digit_cathode_en)
		`CHK("reset segments", SEG_OFF, segment_drive)
		repeat (2) @(posedge ref_clk);
		rd(ADDR_CTRL, {26'h0, CTRL_RST}, 32'hffff_ffff, RESP_OKAY, "ctrl");
		$display("test reset done");
		repeat (4)
		begin
			d = $random(seed);
			wr(ADDR_CTRL, d, 4'hf, RESP_OKAY);
			rd(ADDR_CTRL, {26'h0, d[5:0]}, 32'hffff_ffff, RESP_OKAY, "ctrl");
		end
		wr(ADDR_CTRL, 32'h3f, 4'he, RESP_OKAY);
		rd(ADDR_CTRL, {26'h0, d[5:0]}, 32'hffff_ffff, RESP_OKAY, "ctrl");
		wr(ADDR_RESULT, 32'h1, 4'hf, RESP_SLVERR);
		rd(4'h2, 32'h0, 32'hffff_ffff, RESP_SLVERR, "unmapped");
		$display("test registers done");
		lvl <= 1'h1;
		rnd_on <= 1'h0;
		wr(ADDR_CTRL, 32'h0, 4'hf, RESP_OKAY);
		wr(ADDR_CTRL, 32'h20, 4'hf, RESP_OKAY);
		half <= 1'h1;
		rv = 32'h0;
		for (int k = 0; k < 80 && rv[0] !== 1'h1; k++)
		begin
			repeat (1000) @(posedge ref_clk);
			rd(ADDR_STATUS, 32'h0, 32'h0, RESP_OKAY, "status");
		end
		rd(ADDR_RESULT, 32'h9c4, 32'hffff_ffff, RESP_OKAY, "result");
		rd(ADDR_STATUS, 32'h3, 32'hf, RESP_OKAY, "status");
		for (int k = 0; k < 20 && rv !== 32'h9c4; k++)
		begin
			repeat (1000) @(posedge ref_clk);
			rd(ADDR_SHOWN, 32'h0, 32'h0, RESP_OKAY, "shown");
		end
		rd(ADDR_SHOWN, 32'h9c4, 32'hffff_ffff, RESP_OKAY, "shown");
		$display("test filter done");
		scan("overrange", 11500);
		`CHK("scan period", 5 * ON_P, scan_len)
		wr(ADDR_CTRL, 32'h38, 4'hf, RESP_OKAY);
		lvl <= 1'h0;
		repeat (27000) @(posedge ref_clk);
		rd(ADDR_SHOWN, 32'h9c4, 32'hffff_ffff, RESP_OKAY, "shown");
		rd(ADDR_STATUS, 32'hb, 32'hf, RESP_OKAY, "status");
		scan("hold", 6000);
		test_done;
	end
endmodule
`default_nettype wire
